// *** hdl/npic_params.svh ***
// Constants of the nested priority interrupt controller
`ifndef NPIC_PARAMS_SVH
`define NPIC_PARAMS_SVH
// Level bit positions inside the condition code register
`define NPIC_CC_HIGH_POS   5
`define NPIC_CC_LOW_POS    3
// Level codes on the {high, low} bit pair
`define NPIC_LVL0_CODE     2'b10
`define NPIC_LVL1_CODE     2'b01
`define NPIC_LVL2_CODE     2'b00
`define NPIC_LVL3_CODE     2'b11
// Vector addresses
`define NPIC_VEC_RESET     16'hfffe
`define NPIC_VEC_TRAP      16'hfffc
`define NPIC_VEC_TOP       16'hfffa
`define NPIC_VEC_BASE      16'hffe0
// Register addresses of the four priority registers
`define NPIC_PRIO0_ADDR    4'h0
`define NPIC_PRIO1_ADDR    4'h1
`define NPIC_PRIO2_ADDR    4'h2
`define NPIC_PRIO3_ADDR    4'h3
`define NPIC_PRIO_RESET    8'hff
// Sources 0..13 (0 is the external non-maskable source)
`define NPIC_NUM_SRC       14
`define NPIC_HALT_WAKE     14'h003f
`endif

// *** hdl/npic_pkg.sv ***
// Types of the nested priority interrupt controller
package npic_pkg;
	typedef enum logic [1:0] {
		NPIC_SEL_NONE,
		NPIC_SEL_RESET,
		NPIC_SEL_TRAP,
		NPIC_SEL_VEC
	} npic_sel_t;
endpackage : npic_pkg

// *** hdl/npic_core.sv ***
// Nested priority interrupt controller logic
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "npic_params.svh"
module npic_core
	import npic_pkg::*;
#(
	parameter int NUM_SRC = `NPIC_NUM_SRC
) (
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// Register port
	input  wire logic [3:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	// External non-maskable pin and its edge select (1 = rising)
	input  wire logic                nmi_pin,
	input  wire logic                nmi_rising_sel,
	// External interrupt pins, one group per line, with edge/level mode
	input  wire logic [4:0][7:0]     ext_pins,
	input  wire logic [4:0][7:0]     ext_pin_sel,
	input  wire logic [4:0]          ext_edge_mode,
	// Peripheral sources 6..13: flag, enable, clear sequence
	input  wire logic [7:0]          periph_flag,
	input  wire logic [7:0]          periph_enable,
	input  wire logic [7:0]          periph_clear,
	// Core sequencing
	input  wire logic                insn_boundary,
	input  wire logic                trap_exec,
	input  wire logic                ret_exec,
	input  wire logic [1:0]          ret_level,
	input  wire logic                sw_level_wr,
	input  wire logic [1:0]          sw_level,
	input  wire logic                wait_mode,
	input  wire logic                halt_mode,
	output logic                     irq_take,
	output logic      [15:0]         irq_vector,
	output logic                     wake,
	output logic      [7:0]          condition_code_reg
);

	// ******************************************************
	// Helpers
	// ******************************************************

	// Level code to rank 0..3
	function automatic logic [1:0] lvl_rank(input logic [1:0] code);
		case (code)
			`NPIC_LVL0_CODE: lvl_rank = 2'd0;
			`NPIC_LVL1_CODE: lvl_rank = 2'd1;
			`NPIC_LVL2_CODE: lvl_rank = 2'd2;
			default:         lvl_rank = 2'd3;
		endcase
	endfunction : lvl_rank

	// Merge a written field; level 0 code keeps the old value
	function automatic logic [1:0] keep_field(input logic [1:0] old_v,
		input logic [1:0] new_v);
		keep_field = (new_v == `NPIC_LVL0_CODE) ? old_v : new_v;
	endfunction : keep_field

	// ******************************************************
	// Input synchronisers (three stages, second and third agree)
	// ******************************************************

	logic [2:0]       nmi_sync_reg;
	logic             nmi_stable_reg;
	logic [4:0][7:0]  ext_s1_reg;
	logic [4:0][7:0]  ext_s2_reg;
	logic [4:0][7:0]  ext_s3_reg;
	logic [4:0]       ext_line_reg;
	logic [4:0]       ext_line_prev_reg;

	// Pin sampling; only stages two and three feed logic
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			nmi_sync_reg <= 3'h0;
			ext_s1_reg   <= '0;
			ext_s2_reg   <= '0;
			ext_s3_reg   <= '0;
		end else begin
			nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin};
			ext_s1_reg   <= ext_pins;
			ext_s2_reg   <= ext_s1_reg;
			ext_s3_reg   <= ext_s2_reg;
		end
	end

	// Filtered levels: change only when stages two and three agree
	logic [4:0] ext_line_next;
	always_comb begin
		for (int g = 0; g < 5; g++) begin
			ext_line_next[g] = |(ext_s2_reg[g] & ext_s3_reg[g]
				& ext_pin_sel[g]);
			if (|((ext_s2_reg[g] ^ ext_s3_reg[g]) & ext_pin_sel[g]))
				ext_line_next[g] = ext_line_reg[g];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			nmi_stable_reg    <= 1'b0;
			ext_line_reg      <= 5'h0;
			ext_line_prev_reg <= 5'h0;
		end else begin
			if (nmi_sync_reg[2] == nmi_sync_reg[1])
				nmi_stable_reg <= nmi_sync_reg[2];
			ext_line_reg      <= ext_line_next;
			ext_line_prev_reg <= ext_line_reg;
		end
	end

	logic nmi_prev_reg;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			nmi_prev_reg <= 1'b0;
		else
			nmi_prev_reg <= nmi_stable_reg;
	end

	// Selected edge on the non-maskable pin
	logic nmi_edge;
	assign nmi_edge = nmi_rising_sel ? (nmi_stable_reg & ~nmi_prev_reg)
		: (~nmi_stable_reg & nmi_prev_reg);

	// ******************************************************
	// Priority registers
	// ******************************************************

	logic [7:0] prio_reg [4];

	// Software writes; level 0 fields are refused per field
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int r = 0; r < 4; r++)
				prio_reg[r] <= `NPIC_PRIO_RESET;
		end else if (reg_wr && reg_addr <= `NPIC_PRIO3_ADDR) begin
			for (int f = 0; f < 4; f++)
				prio_reg[reg_addr[1:0]][2*f +: 2] <=
					keep_field(prio_reg[reg_addr[1:0]][2*f +: 2],
					reg_wdata[2*f +: 2]);
			// Top half of the last register is read-only ones
			if (reg_addr == `NPIC_PRIO3_ADDR)
				prio_reg[3][7:4] <= 4'hf;
		end
	end

	// Read data one cycle after the strobe; unmapped reads as zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd && reg_addr <= `NPIC_PRIO3_ADDR)
			reg_rdata <= prio_reg[reg_addr[1:0]];
		else
			reg_rdata <= 8'h00;
	end

	// Field of source s
	function automatic logic [1:0] src_prio(input int s);
		src_prio = prio_reg[s / 4][2*(s % 4) +: 2];
	endfunction : src_prio

	// Sources that may end halt; a literal cannot be bit-selected
	localparam logic [NUM_SRC-1:0] halt_wake_mask =
		NUM_SRC'(`NPIC_HALT_WAKE);

	// ******************************************************
	// Request latches
	// ******************************************************

	logic [NUM_SRC-1:0] pend_reg;
	logic               nmi_pend_reg;
	logic               trap_pend_reg;
	logic               reset_pend_reg;
	logic [NUM_SRC-1:0] raw_req;
	logic [NUM_SRC-1:0] clr_on_entry;
	npic_sel_t          sel;
	logic [3:0]         win_idx;

	// Level-sensitive or edge-latched external lines, peripherals
	always_comb begin
		raw_req    = '0;
		raw_req[0] = nmi_pend_reg;
		for (int g = 0; g < 5; g++)
			raw_req[g+1] = ext_edge_mode[g] ? pend_reg[g+1]
				: ext_line_reg[g];
		for (int p = 0; p < 8; p++)
			if (p + 6 < NUM_SRC)
				raw_req[p+6] = periph_flag[p] & periph_enable[p];
	end

	// Edge lines latch; entry clears (set wins over clear)
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pend_reg <= '0;
		end else begin
			for (int g = 0; g < 5; g++) begin
				if (ext_line_reg[g] & ~ext_line_prev_reg[g])
					pend_reg[g+1] <= 1'b1;
				else if (clr_on_entry[g+1])
					pend_reg[g+1] <= 1'b0;
			end
		end
	end

	// Peripheral requests track the flag, so a clear drops them
	logic [7:0] periph_drop;
	assign periph_drop = periph_clear;

	// Non-maskable latches
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			nmi_pend_reg   <= 1'b0;
			trap_pend_reg  <= 1'b0;
			reset_pend_reg <= 1'b1;
		end else begin
			if (nmi_edge)
				nmi_pend_reg <= 1'b1;
			else if (irq_take && sel == NPIC_SEL_VEC && win_idx == 4'd0)
				nmi_pend_reg <= 1'b0;
			if (trap_exec)
				trap_pend_reg <= 1'b1;
			else if (irq_take && sel == NPIC_SEL_TRAP)
				trap_pend_reg <= 1'b0;
			if (irq_take && sel == NPIC_SEL_RESET)
				reset_pend_reg <= 1'b0;
		end
	end

	// ******************************************************
	// Arbitration
	// ******************************************************

	logic [1:0] cur_lvl;
	logic [1:0] best_rank;
	logic       found;
	logic       halt_exit_reg;
	logic [NUM_SRC-1:0] eligible;

	// Best source: non-maskable first, then rank, then low index
	always_comb begin
		eligible  = '0;
		found     = 1'b0;
		best_rank = 2'd0;
		win_idx   = 4'd0;
		sel       = NPIC_SEL_NONE;
		cur_lvl   = lvl_rank({condition_code_reg[`NPIC_CC_HIGH_POS],
			condition_code_reg[`NPIC_CC_LOW_POS]});
		for (int s = 0; s < NUM_SRC; s++) begin
			eligible[s] = raw_req[s] & ~(s >= 6 && periph_drop[s-6]
				&& s - 6 < 8);
			if (s != 0 && lvl_rank(src_prio(s)) <= cur_lvl)
				eligible[s] = 1'b0;
			if (halt_exit_reg && !halt_wake_mask[s])
				eligible[s] = 1'b0;
		end
		// Lower index is higher hardware priority; strict > keeps it
		for (int s = 0; s < NUM_SRC; s++) begin
			if (eligible[s] && (!found || (s != 0 && !win_idx_is_nmi(win_idx)
				&& lvl_rank(src_prio(s)) > best_rank))) begin
				found     = 1'b1;
				win_idx   = 4'(s);
				best_rank = (s == 0) ? 2'd3 : lvl_rank(src_prio(s));
			end
		end
		if (reset_pend_reg)
			sel = NPIC_SEL_RESET;
		else if (trap_pend_reg)
			sel = NPIC_SEL_TRAP;
		else if (found)
			sel = NPIC_SEL_VEC;
	end

	function automatic logic win_idx_is_nmi(input logic [3:0] i);
		win_idx_is_nmi = (i == 4'd0);
	endfunction : win_idx_is_nmi

	// Taken only at an instruction boundary, outside low power modes
	assign irq_take = insn_boundary && !wait_mode && !halt_mode
		&& sel != NPIC_SEL_NONE;

	// Edge entries clear their own latch
	always_comb begin
		clr_on_entry = '0;
		if (irq_take && sel == NPIC_SEL_VEC)
			clr_on_entry[win_idx] = 1'b1;
	end

	// Wake: any request ends wait, only halt-capable end halt
	always_comb begin
		wake = 1'b0;
		if (wait_mode && (|raw_req || trap_pend_reg || reset_pend_reg))
			wake = 1'b1;
		if (halt_mode && (|(raw_req & halt_wake_mask) || trap_pend_reg
			|| reset_pend_reg))
			wake = 1'b1;
	end

	// Halt exit window lasts until the first service
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			halt_exit_reg <= 1'b0;
		else if (halt_mode && wake)
			halt_exit_reg <= 1'b1;
		else if (irq_take)
			halt_exit_reg <= 1'b0;
	end

	// ******************************************************
	// Vector and level outputs
	// ******************************************************

	// Vector registered with the take strobe's cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_vector <= `NPIC_VEC_RESET;
		end else if (irq_take) begin
			case (sel)
				NPIC_SEL_RESET: irq_vector <= `NPIC_VEC_RESET;
				NPIC_SEL_TRAP:  irq_vector <= `NPIC_VEC_TRAP;
				default: irq_vector <= 16'(`NPIC_VEC_TOP
					- {win_idx, 1'b0});
			endcase
		end
	end

	// Stored field of the winner; a function result cannot be bit-selected
	logic [1:0] win_prio;
	always_comb begin
		win_prio = src_prio(int'(win_idx));
	end

	// Condition code level bits; other bits read as reset pattern
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			condition_code_reg <= 8'hea;
		end else if (irq_take) begin
			if (sel == NPIC_SEL_VEC && win_idx != 4'd0) begin
				condition_code_reg[`NPIC_CC_HIGH_POS] <=
					win_prio[1];
				condition_code_reg[`NPIC_CC_LOW_POS]  <=
					win_prio[0];
			end else begin
				condition_code_reg[`NPIC_CC_HIGH_POS] <= 1'b1;
				condition_code_reg[`NPIC_CC_LOW_POS]  <= 1'b1;
			end
		end else if (ret_exec) begin
			condition_code_reg[`NPIC_CC_HIGH_POS] <= ret_level[1];
			condition_code_reg[`NPIC_CC_LOW_POS]  <= ret_level[0];
		end else if (sw_level_wr) begin
			condition_code_reg[`NPIC_CC_HIGH_POS] <= sw_level[1];
			condition_code_reg[`NPIC_CC_LOW_POS]  <= sw_level[0];
		end
	end

endmodule : npic_core

// *** verif/npic_core_assertions.sv ***
// Port checker of the nested priority interrupt controller
`timescale 1ns/1ps
module npic_core_chk (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        insn_boundary,
	input wire logic        wait_mode,
	input wire logic        halt_mode,
	input wire logic        ret_exec,
	input wire logic [1:0]  ret_level,
	input wire logic        sw_level_wr,
	input wire logic [1:0]  sw_level,
	input wire logic        irq_take,
	input wire logic [15:0] irq_vector,
	input wire logic [7:0]  condition_code_reg
);
	// **********
	// Helpers
	// **********
	wire [1:0] lvl = {condition_code_reg[5], condition_code_reg[3]};
	wire       calm = !irq_take && !ret_exec && !sw_level_wr;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Takes only at a boundary of a running core
	chk_take_boundary: assert property (
		irq_take |-> insn_boundary && !wait_mode && !halt_mode)
		else $error("take off an instruction boundary");
	chk_vec_range: assert property (
		irq_take |=> !irq_vector[0] && irq_vector >= 16'hffe0)
		else $error("vector outside the table");
	chk_masked_out: assert property (
		irq_take && lvl == 2'b11 |=> irq_vector >= 16'hfffa)
		else $error("maskable taken at level 3");
	chk_nm_level: assert property (
		irq_take |=> irq_vector < 16'hfffa || lvl == 2'b11)
		else $error("non-maskable entry not at level 3");
	chk_ret_level: assert property (
		ret_exec |=> lvl == $past(ret_level))
		else $error("return did not restore level");
	chk_sw_level: assert property (
		sw_level_wr |=> lvl == $past(sw_level))
		else $error("software level not loaded");
	// Level bits only move on take, return or software write
	chk_cc_stable: assert property (
		calm |=> $stable(condition_code_reg))
		else $error("condition code moved unprompted");
	chk_vec_hold: assert property (
		calm |=> $stable(irq_vector))
		else $error("vector moved without a take");
	cov_nmi: cover property (irq_take ##1 irq_vector == 16'hfffa);
	cov_ret: cover property (ret_exec);
	cov_halt: cover property (halt_mode ##1 !halt_mode);
endmodule : npic_core_chk
bind npic_core npic_core_chk i_chk (.ref_clk(ref_clk), .rst(rst),
	.insn_boundary(insn_boundary), .wait_mode(wait_mode),
	.halt_mode(halt_mode), .ret_exec(ret_exec), .ret_level(ret_level),
	.sw_level_wr(sw_level_wr), .sw_level(sw_level), .irq_take(irq_take),
	.irq_vector(irq_vector), .condition_code_reg(condition_code_reg));

// *** verif/npic_cpu_model.sv ***
// Behavioural core that sequences takes and returns
`timescale 1ns/1ps
module npic_cpu_model (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       irq_take,
	input  wire logic [7:0] condition_code_reg,
	input  wire logic       ret_req,
	output logic            insn_boundary,
	output logic            ret_exec,
	output logic      [1:0] ret_level
);
	logic [1:0] step_reg;
	logic       pend_reg;
	logic [1:0] stack_q [$];
	wire  [1:0] lvl = {condition_code_reg[5], condition_code_reg[3]};
	// Four-cycle instructions, takes only land at their end
	assign insn_boundary = (step_reg == 2'd3);
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			step_reg  <= 2'd0;
			pend_reg  <= 1'b0;
			ret_exec  <= 1'b0;
			ret_level <= 2'b11;
			stack_q.delete();
		end else begin
			step_reg <= step_reg + 2'd1;
			ret_exec <= 1'b0;
			// Context push keeps only the level bits of the condition code
			if (irq_take)
				stack_q.push_back(lvl);
			if (ret_req)
				pend_reg <= 1'b1;
			// Return lands mid-instruction so it never meets a take
			if (pend_reg && step_reg == 2'd1 && stack_q.size() > 0) begin
				ret_exec  <= 1'b1;
				ret_level <= stack_q.pop_back();
				pend_reg  <= 1'b0;
			end
		end
	end
endmodule : npic_cpu_model

// *** verif/test_npic_core.sv ***
// Self-checking testbench of the interrupt controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module test_npic_core;
	logic            ref_clk = 1'b0;
	logic            rst = 1'b1;
	logic [3:0]      reg_addr = 4'h0;
	logic [7:0]      reg_wdata = 8'h00;
	logic            reg_wr = 1'b0;
	logic            reg_rd = 1'b0;
	logic            nmi_pin = 1'b0;
	logic [4:0][7:0] ext_pins = '0;
	logic [4:0][7:0] ext_pin_sel = 40'h0101;
	logic [7:0]      periph_flag = 8'h00;
	logic [7:0]      periph_enable = 8'h00;
	logic [7:0]      periph_clear = 8'h00;
	logic            trap_exec = 1'b0;
	logic            sw_level_wr = 1'b0;
	logic [1:0]      sw_level = 2'b11;
	logic            halt_mode = 1'b0;
	logic            wait_mode = 1'b0;
	logic            nmi_rising_sel = 1'b1;
	logic            ret_req = 1'b0;
	logic            insn_boundary, ret_exec, irq_take, wake;
	logic [1:0]      ret_level;
	logic [15:0]     irq_vector;
	logic [7:0]      reg_rdata, condition_code_reg;
	int              errors = 0;
	int              cmp_count = 0;
	always #10 ref_clk = ~ref_clk;
	npic_core i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .nmi_pin(nmi_pin),
		.nmi_rising_sel(nmi_rising_sel),
		.ext_pins(ext_pins), .ext_pin_sel(ext_pin_sel),
		.ext_edge_mode(5'h1f), .periph_flag(periph_flag),
		.periph_enable(periph_enable), .periph_clear(periph_clear),
		.insn_boundary(insn_boundary), .trap_exec(trap_exec),
		.ret_exec(ret_exec), .ret_level(ret_level),
		.sw_level_wr(sw_level_wr), .sw_level(sw_level),
		.wait_mode(wait_mode),
		.halt_mode(halt_mode), .irq_take(irq_take), .irq_vector(irq_vector),
		.wake(wake), .condition_code_reg(condition_code_reg));
	npic_cpu_model i_cpu (.ref_clk(ref_clk), .rst(rst), .irq_take(irq_take),
		.condition_code_reg(condition_code_reg), .ret_req(ret_req),
		.insn_boundary(insn_boundary), .ret_exec(ret_exec),
		.ret_level(ret_level));
	// ****************
	// Access tasks
	// ****************
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		`CHK("rdata", e, reg_rdata)
	endtask : rd
	task automatic setlvl(input logic [1:0] l);
		@(posedge ref_clk);
		sw_level    <= l;
		sw_level_wr <= 1'b1;
		@(posedge ref_clk);
		sw_level_wr <= 1'b0;
	endtask : setlvl
	task automatic ret();
		int n;
		n = 0;
		@(posedge ref_clk);
		ret_req <= 1'b1;
		@(posedge ref_clk);
		ret_req <= 1'b0;
		// Leaves at the edge the return lands, so no level write meets it
		do @(posedge ref_clk); while (ret_exec !== 1'b1 && ++n < 16);
		`CHK("return", 1'b1, ret_exec)
	endtask : ret
	// Waits a bounded time, then checks vector and new level
	task automatic take(input logic [15:0] v, input logic [1:0] l);
		int n;
		n = 0;
		do @(negedge ref_clk); while (irq_take !== 1'b1 && ++n < 200);
		`CHK("take", 1'b1, irq_take)
		@(negedge ref_clk);
		`CHK("vector", v, irq_vector)
		`CHK("level", l, {condition_code_reg[5], condition_code_reg[3]})
	endtask : take
	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge ref_clk);
			seen = seen | irq_take;
		end
		`CHK("idle", 1'b0, seen)
	endtask : quiet
	task automatic stop_test();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	// ****************
	// Scenarios
	// ****************
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		take(16'hfffe, 2'b11);
		for (int i = 0; i < 4; i++) rd(i[3:0], 8'hff);
		wr(4'h0, 8'hcf);
		wr(4'h0, 8'h64);
		rd(4'h0, 8'h44);
		wr(4'h1, 8'h1f);
		setlvl(2'b10);
		@(posedge ref_clk);
		periph_flag <= 8'h03;
		quiet(12);
		@(posedge ref_clk);
		periph_enable <= 8'h03;
		take(16'hffec, 2'b00);
		quiet(12);
		@(posedge ref_clk);
		periph_clear <= 8'h02;
		periph_flag  <= 8'h01;
		@(posedge ref_clk);
		periph_clear <= 8'h00;
		ret();
		take(16'hffee, 2'b01);
		@(posedge ref_clk);
		periph_flag <= 8'h00;
		ret();
		setlvl(2'b11);
		nmi_pin <= 1'b1;
		take(16'hfffa, 2'b11);
		ret();
		trap_exec <= 1'b1;
		@(posedge ref_clk);
		trap_exec <= 1'b0;
		take(16'hfffc, 2'b11);
		ret();
		setlvl(2'b10);
		ext_pins[0][0] <= 1'b1;
		take(16'hfff8, 2'b01);
		ret();
		ext_pins[0][0] <= 1'b0;
		quiet(16);
		wr(4'h1, 8'h3f);
		@(posedge ref_clk);
		halt_mode   <= 1'b1;
		periph_flag <= 8'h01;
		quiet(12);
		`CHK("wake", 1'b0, wake)
		@(posedge ref_clk);
		ext_pins[1][0] <= 1'b1;
		repeat (12) @(negedge ref_clk);
		`CHK("wake", 1'b1, wake)
		@(posedge ref_clk);
		halt_mode <= 1'b0;
		take(16'hfff6, 2'b00);
		take(16'hffee, 2'b11);
		// Wait mode ends only on a live request
		@(posedge ref_clk);
		periph_flag <= 8'h00;
		wait_mode   <= 1'b1;
		@(negedge ref_clk);
		`CHK("wake", 1'b0, wake)
		@(posedge ref_clk);
		periph_flag <= 8'h01;
		@(negedge ref_clk);
		`CHK("wake", 1'b1, wake)
		// Falling edge selected on the non-maskable pin
		@(posedge ref_clk);
		wait_mode      <= 1'b0;
		nmi_rising_sel <= 1'b0;
		nmi_pin        <= 1'b0;
		take(16'hfffa, 2'b11);
		stop_test();
	end
	// Cuts a hang short well past the scenarios' length
	initial begin
		repeat (6000) @(posedge ref_clk);
		errors++;
		stop_test();
	end
endmodule : test_npic_core
